// file: rtl/nbe_pkg.sv
// constants and types of the on-die correction and bad-block guard
// assumes a command decoder and a codec datapath outside this block
// Functional notes
// - program or erase of a factory-bad block is dropped and flags its fail bit
// - bad-block protection is always on; no setting can disable it
// - parity is made during program; 9-bit detect, 8-bit correct per 528 bytes
// - codeword n is main column n*512 plus spare column 4096+n*16
// - read correction is automatic; status holds until the next valid operation
// - parity lives at columns 4224-4351, closed to the host while correction is on
// - correction enable is bit 4 of location b0h, set after power-up
// - with correction off the usable spare grows from 128 to 256 bytes
// - correction outcome sits in bits 5:4 of location c0h
// - four-bit flip threshold is held at location 10h, written by set-feature
// - codes 1..8 pick 1..8 flips, 1111 picks uncorrectable, 0000 reserved
// - threshold resets to code 0100
// - location 20h bit n is set when sector n count reaches the threshold
// - threshold flags update only on the read-buffer command after a page read
// - four-bit flip count per sector at 40h and 50h, 1111 means uncorrected
// - location 30h gives page maximum count and its lowest sector index
`default_nettype none
package nbe_pkg;
  localparam logic [7:0]  FA_THRESH     = 8'h10;
  localparam logic [7:0]  FA_FLAGS      = 8'h20;
  localparam logic [7:0]  FA_MAX        = 8'h30;
  localparam logic [7:0]  FA_CNT_LO     = 8'h40;
  localparam logic [7:0]  FA_CNT_HI     = 8'h50;
  localparam logic [7:0]  FA_CFG        = 8'hb0;
  localparam logic [7:0]  FA_STAT       = 8'hc0;
  localparam int          ECC_EN_BIT    = 4;
  localparam int          OUTCOME_LSB   = 4;
  localparam int          PFAIL_BIT     = 3;
  localparam int          EFAIL_BIT     = 2;
  localparam int          NUM_SECTORS   = 8;
  localparam logic        ECC_EN_RST    = 1'b1;
  localparam logic [3:0]  THRESH_RST    = 4'h4;
  localparam logic [3:0]  CNT_MAXCORR   = 4'h8;
  localparam logic [3:0]  CNT_UNCORR    = 4'hf;
  localparam logic [12:0] COL_SPARE     = 13'h1000;
  localparam logic [12:0] COL_PARITY    = 13'h1080;
  localparam logic [12:0] COL_LAST      = 13'h10ff;
  localparam logic [8:0]  SPARE_ON      = 9'h080;
  localparam logic [8:0]  SPARE_OFF     = 9'h100;
  localparam logic [1:0]  OUT_NONE      = 2'h0;
  localparam logic [1:0]  OUT_CORR      = 2'h1;
  localparam logic [1:0]  OUT_UNCORR    = 2'h2;

  typedef enum logic [2:0] {
    CMD_OTHER     = 3'h0,
    CMD_PAGE_READ = 3'h1,
    CMD_READ_BUF  = 3'h2,
    CMD_PROGRAM   = 3'h3,
    CMD_ERASE     = 3'h4
  } nbe_cmd_e;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_DECODE = 3'b010,
    ST_HOLD   = 3'b100
  } nbe_state_e;
endpackage : nbe_pkg
`default_nettype wire

// file: rtl/nbe_ecc_guard.sv
// correction control, flip reporting, feature table and bad-block guard
// assumes a command decoder on clk and an external codec that reports
// per-sector flip counts and builds parity when enc_start pulses
`default_nettype none
module nbe_ecc_guard (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             cmd_valid,
  input  wire nbe_pkg::nbe_cmd_e cmd_code,
  input  wire logic             cmd_block_bad,
  output logic                  op_go,
  output logic                  op_refused,
  output logic                  enc_start,
  input  wire logic             dec_valid,
  input  wire logic [2:0]       dec_sector,
  input  wire logic [3:0]       dec_flips,
  input  wire logic             dec_done,
  input  wire logic             feat_wr,
  input  wire logic             feat_rd,
  input  wire logic [7:0]       feat_addr,
  input  wire logic [7:0]       feat_wdata,
  output logic [15:0]           feat_rdata,
  input  wire logic [12:0]      col_addr,
  output logic                  col_ok,
  output logic [2:0]            col_sector,
  output logic                  col_spare,
  output logic                  ecc_enabled,
  output logic [8:0]            spare_size
);
  import nbe_pkg::*;

  nbe_state_e  state_ff;
  nbe_state_e  nxt_state;
  logic        ecc_en_ff;
  logic [3:0]  thresh_ff;
  logic [31:0] cnt_ff;
  logic [31:0] nxt_cnt;
  logic [7:0]  flags_ff;
  logic [7:0]  nxt_flags;
  logic [1:0]  outcome_ff;
  logic        pfail_ff;
  logic        efail_ff;
  logic [3:0]  max_ff;
  logic [2:0]  max_sec_ff;
  logic        op_go_ff;
  logic        op_refused_ff;
  logic        enc_start_ff;
  logic        op_ecc_ff;
  logic [15:0] rdata_ff;
  logic [15:0] rd_mux;

  // command classification
  wire is_read   = cmd_valid && (cmd_code == CMD_PAGE_READ);
  wire is_rbuf   = cmd_valid && (cmd_code == CMD_READ_BUF);
  wire is_prog   = cmd_valid && (cmd_code == CMD_PROGRAM);
  wire is_erase  = cmd_valid && (cmd_code == CMD_ERASE);
  wire is_op     = is_read || is_prog || is_erase;
  // no enable term here: the guard cannot be switched off
  wire refuse    = (is_prog || is_erase) && cmd_block_bad;
  wire go        = is_op && !refuse;
  wire commit    = is_rbuf && (state_ff == ST_HOLD);
  wire dec_take  = dec_valid && (state_ff == ST_DECODE) && op_ecc_ff;
  wire dec_end   = dec_done && (state_ff == ST_DECODE);

  // codec reports the raw count; anything past the correctable limit is 1111
  wire [3:0] dec_enc = (dec_flips > CNT_MAXCORR) ? CNT_UNCORR : dec_flips;

  // column map: main columns pick sector by 512, spare columns by 16
  assign col_spare  = (col_addr >= COL_SPARE);
  assign col_sector = col_spare ? col_addr[6:4] : col_addr[11:9];
  assign spare_size = ecc_en_ff ? SPARE_ON : SPARE_OFF;
  // parity columns are closed while correction is on; beyond the spare is never valid
  assign col_ok     = (col_addr <= COL_LAST) &&
                      !(ecc_en_ff && (col_addr >= COL_PARITY));
  assign ecc_enabled = ecc_en_ff;
  assign op_go       = op_go_ff;
  assign op_refused  = op_refused_ff;
  assign enc_start   = enc_start_ff;
  assign feat_rdata  = rdata_ff;

  // page maximum: strict compare keeps the lowest sector on ties
  logic [3:0] best_cnt;
  logic [2:0] best_sec;
  always_comb begin
    best_cnt = 4'h0;
    best_sec = 3'h0;
    for (int i = 0; i < NUM_SECTORS; i++) begin
      if (cnt_ff[i*4 +: 4] > best_cnt) begin
        best_cnt = cnt_ff[i*4 +: 4];
        best_sec = 3'(i);
      end
    end
  end

  // per-sector counts: a new read wipes the old page before decoding
  always_comb begin
    nxt_cnt = cnt_ff;
    if (go && is_read) begin
      nxt_cnt = 32'h0000_0000;
    end else if (dec_take) begin
      nxt_cnt[dec_sector*4 +: 4] = dec_enc;
    end
  end

  // threshold compare; code 0000 never flags, 1111 only catches uncorrectable
  always_comb begin
    nxt_flags = flags_ff;
    if (commit) begin
      for (int i = 0; i < NUM_SECTORS; i++) begin
        nxt_flags[i] = (thresh_ff != 4'h0) && (cnt_ff[i*4 +: 4] >= thresh_ff);
      end
    end
  end

  // sequencing of a page read through decode and the flag commit
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (go && is_read) nxt_state = ST_DECODE;
      end
      ST_DECODE: begin
        if (go && is_read) nxt_state = ST_DECODE;
        else if (dec_end) nxt_state = ST_HOLD;
      end
      ST_HOLD: begin
        if (go && is_read) nxt_state = ST_DECODE;
        else if (commit) nxt_state = ST_IDLE;
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  // feature read mux; unmapped locations read as zero
  always_comb begin
    case (feat_addr)
      FA_THRESH: rd_mux = {12'h000, thresh_ff};
      FA_FLAGS:  rd_mux = {8'h00, flags_ff};
      FA_MAX:    rd_mux = {8'h00, max_ff, 1'b0, max_sec_ff};
      FA_CNT_LO: rd_mux = cnt_ff[15:0];
      FA_CNT_HI: rd_mux = cnt_ff[31:16];
      FA_CFG:    rd_mux = 16'(8'(ecc_en_ff) << ECC_EN_BIT);
      FA_STAT:   rd_mux = 16'({outcome_ff, pfail_ff, efail_ff, 2'b00});
      default:   rd_mux = 16'h0000;
    endcase
  end

  // state, counts and flags
  always_ff @(posedge clk) begin
    if (srst) begin
      state_ff <= ST_IDLE;
      cnt_ff   <= 32'h0000_0000;
      flags_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      flags_ff <= nxt_flags;
    end
  end

  // settings written by set-feature; other bits of b0h are not kept here
  always_ff @(posedge clk) begin
    if (srst) begin
      ecc_en_ff <= ECC_EN_RST;
      thresh_ff <= THRESH_RST;
    end else if (feat_wr) begin
      if (feat_addr == FA_CFG) ecc_en_ff <= feat_wdata[ECC_EN_BIT];
      if (feat_addr == FA_THRESH) thresh_ff <= feat_wdata[3:0];
    end
  end

  // operation handshake; the enable is sampled as each operation starts
  always_ff @(posedge clk) begin
    if (srst) begin
      op_go_ff      <= 1'b0;
      op_refused_ff <= 1'b0;
      enc_start_ff  <= 1'b0;
      op_ecc_ff     <= ECC_EN_RST;
    end else begin
      op_go_ff      <= go;
      op_refused_ff <= refuse;
      enc_start_ff  <= go && is_prog && ecc_en_ff;
      if (go) op_ecc_ff <= ecc_en_ff;
    end
  end

  // status at c0h: kept until the next read, program or erase is issued, even a refused one
  always_ff @(posedge clk) begin
    if (srst) begin
      outcome_ff <= OUT_NONE;
      pfail_ff   <= 1'b0;
      efail_ff   <= 1'b0;
      max_ff     <= 4'h0;
      max_sec_ff <= 3'h0;
    end else if (is_op) begin
      outcome_ff <= OUT_NONE;
      pfail_ff   <= refuse && is_prog;
      efail_ff   <= refuse && is_erase;
      if (go && is_read) begin
        max_ff     <= 4'h0;
        max_sec_ff <= 3'h0;
      end
    end else if (dec_end) begin
      max_ff     <= best_cnt;
      max_sec_ff <= best_sec;
      outcome_ff <= (best_cnt == CNT_UNCORR) ? OUT_UNCORR :
                    (best_cnt == 4'h0) ? OUT_NONE : OUT_CORR;
    end
  end

  // registered feature read data, one cycle after the read strobe
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_ff <= 16'h0000;
    end else if (feat_rd) begin
      rdata_ff <= rd_mux;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_bad_op;
    cmd_valid && cmd_block_bad && (cmd_code inside {CMD_PROGRAM, CMD_ERASE});
  endsequence

  sequence s_read_start;
    cmd_valid && (cmd_code == CMD_PAGE_READ);
  endsequence

  sequence s_commit;
    cmd_valid && (cmd_code == CMD_READ_BUF) && (state_ff == ST_HOLD);
  endsequence

  a_bad_fail_flag: assert property (
    s_bad_op |=> op_refused && (pfail_ff || efail_ff) && (pfail_ff != efail_ff))
    else $error("bad block operation did not raise its fail bit");

  a_bad_never_runs: assert property (
    s_bad_op |=> !op_go && !enc_start)
    else $error("operation on a bad block was started");

  a_parity_on_prog: assert property (
    (cmd_valid && cmd_code == CMD_PROGRAM && !cmd_block_bad && ecc_en_ff) |=> enc_start && op_go)
    else $error("program did not start parity generation");

  a_sector_map: assert property (
    (col_addr < COL_SPARE) |-> (col_sector == col_addr[11:9]) && !col_spare)
    else $error("main column mapped to wrong sector");

  a_status_holds: assert property (
    (!(cmd_valid && cmd_code inside {CMD_PAGE_READ, CMD_PROGRAM, CMD_ERASE}) && !dec_end)
    |=> $stable(outcome_ff) && $stable(pfail_ff) && $stable(efail_ff))
    else $error("read status changed without a new operation");

  a_parity_closed: assert property (
    (ecc_en_ff && col_addr >= COL_PARITY && col_addr <= COL_LAST) |-> !col_ok)
    else $error("parity column open while correction on");

  a_reset_values: assert property (
    $fell(srst) |-> ecc_en_ff && (thresh_ff == THRESH_RST) && (flags_ff == 8'h00))
    else $error("wrong values after reset");

  a_spare_size: assert property (
    !ecc_en_ff |-> (spare_size == SPARE_OFF) && col_ok == (col_addr <= COL_LAST))
    else $error("spare area not enlarged with correction off");

  a_flags_wait: assert property (
    !(cmd_valid && (cmd_code == CMD_READ_BUF) && (state_ff == ST_HOLD)) |=> $stable(flags_ff))
    else $error("threshold flags moved without read buffer");

  a_flag_value: assert property (
    s_commit ##1 (thresh_ff == $past(thresh_ff)) |->
      flags_ff[0] == ((thresh_ff != 4'h0) && (cnt_ff[3:0] >= thresh_ff)))
    else $error("sector 0 flag disagrees with threshold");

  a_read_clears: assert property (
    s_read_start |=> (cnt_ff == 32'h0000_0000) && (max_ff == 4'h0) && (state_ff == ST_DECODE))
    else $error("page read did not clear previous counts");

  a_max_sector: assert property (
    (dec_end && !cmd_valid) |=> cnt_ff[max_sec_ff*4 +: 4] == max_ff)
    else $error("reported maximum does not match its sector");

  a_good_op_runs: assert property (
    (cmd_valid && (cmd_code == CMD_PAGE_READ || (!cmd_block_bad && cmd_code inside {CMD_PROGRAM, CMD_ERASE})))
    |=> op_go && !op_refused)
    else $error("accepted operation was not started");

  a_cfg_write: assert property (
    (feat_wr && feat_addr == FA_CFG) |=> ecc_enabled == $past(feat_wdata[ECC_EN_BIT]))
    else $error("correction enable did not follow set-feature");

  a_thresh_write: assert property (
    (feat_wr && feat_addr == FA_THRESH) |=> thresh_ff == $past(feat_wdata[3:0]))
    else $error("threshold did not follow set-feature");

  a_outcome_max: assert property (
    (dec_end && !cmd_valid) |=> (outcome_ff == OUT_UNCORR) == (max_ff == CNT_UNCORR))
    else $error("outcome disagrees with page maximum");
endmodule : nbe_ecc_guard
`default_nettype wire

// file: bench/nbe_codec_model.sv
// behavioural codec: after an accepted page read, reports one sector a cycle
// assumes start is a one-cycle pulse and flips holds encoded per-sector counts
`default_nettype none
module nbe_codec_model (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        start,
  input  wire logic [31:0] flips,
  output logic             dec_valid,
  output logic [2:0]       dec_sector,
  output logic [3:0]       dec_flips,
  output logic             dec_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] idx_ff;
  logic       busy_ff;

  // eight codewords in sector order, then done one cycle after the last report
  always_ff @(posedge clk) begin
    dec_valid <= 1'b0;
    dec_done  <= 1'b0;
    if (srst) begin
      busy_ff    <= 1'b0;
      idx_ff     <= 4'h0;
      dec_sector <= 3'h0;
      dec_flips  <= 4'h0;
    end else if (start) begin
      busy_ff <= 1'b1;
      idx_ff  <= 4'h0;
    end else if (busy_ff && idx_ff == 4'h8) begin
      dec_done <= 1'b1;
      busy_ff  <= 1'b0;
    end else if (busy_ff) begin
      dec_valid  <= 1'b1;
      dec_sector <= idx_ff[2:0];
      dec_flips  <= flips[idx_ff[2:0]*4 +: 4];
      idx_ff     <= idx_ff + 4'h1;
    end else begin
      // idle data toggles so a stale value is never mistaken for a report
      dec_sector <= ~dec_sector;
      dec_flips  <= ~dec_flips;
    end
  end
endmodule : nbe_codec_model
`default_nettype wire

// file: bench/tb_nbe_ecc_guard.sv
// self-checking bench of the correction control and bad-block guard
// assumes the codec model answers each page read taken while armed
`default_nettype none
module tb_nbe_ecc_guard;
  timeunit 1ns;
  timeprecision 1ps;
  import nbe_pkg::*;
  logic        clk = 1'b0, srst = 1'b1, cmd_valid = 1'b0, cmd_block_bad = 1'b0, arm = 1'b0;
  logic        feat_wr = 1'b0, feat_rd = 1'b0;
  nbe_cmd_e    cmd_code = CMD_OTHER;
  logic [7:0]  feat_addr = 8'h00, feat_wdata = 8'h00, prev_flags = 8'h00;
  logic [12:0] col_addr = 13'h0000;
  logic [31:0] flips = 32'h0;
  logic        op_go, op_refused, enc_start, dec_valid, dec_done, col_ok, col_spare, ecc_enabled;
  logic [2:0]  dec_sector, col_sector, r;
  logic [3:0]  dec_flips;
  logic [15:0] feat_rdata, d;
  logic [8:0]  spare_size;
  logic [12:0] corner [7] = '{13'h01ff, 13'h0fff, 13'h1000, 13'h107f, 13'h1080, 13'h10ff, 13'h1100};
  int          n_errors = 0, checks_done = 0, i;

  always #2 clk = ~clk;

  nbe_ecc_guard u_dut (.clk(clk), .srst(srst), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_block_bad(cmd_block_bad), .op_go(op_go), .op_refused(op_refused), .enc_start(enc_start),
    .dec_valid(dec_valid), .dec_sector(dec_sector), .dec_flips(dec_flips), .dec_done(dec_done),
    .feat_wr(feat_wr), .feat_rd(feat_rd), .feat_addr(feat_addr), .feat_wdata(feat_wdata),
    .feat_rdata(feat_rdata), .col_addr(col_addr), .col_ok(col_ok), .col_sector(col_sector),
    .col_spare(col_spare), .ecc_enabled(ecc_enabled), .spare_size(spare_size));
  nbe_codec_model u_codec (.clk(clk), .srst(srst), .start(op_go && arm), .flips(flips),
    .dec_valid(dec_valid), .dec_sector(dec_sector), .dec_flips(dec_flips), .dec_done(dec_done));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic conclude;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude

  // each driver waits a falling edge first, so a strobe stays low a cycle between transfers
  task automatic cmd(input nbe_cmd_e c, input logic bad, output logic [2:0] rsp);
    @(negedge clk);
    cmd_valid = 1'b1; cmd_code = c; cmd_block_bad = bad;
    @(negedge clk);
    rsp = {op_go, op_refused, enc_start};
    cmd_valid = 1'b0;
  endtask : cmd

  task automatic fset(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    feat_wr = 1'b1; feat_addr = a; feat_wdata = v;
    @(negedge clk);
    feat_wr = 1'b0;
  endtask : fset

  task automatic fget(input logic [7:0] a, output logic [15:0] v);
    @(negedge clk);
    feat_rd = 1'b1; feat_addr = a;
    @(negedge clk);
    v = feat_rdata;
    feat_rd = 1'b0;
  endtask : fget

  task automatic cols(input logic on);
    logic [12:0] c;
    for (int k = 0; k < 40; k++) begin
      c = (k < 7) ? corner[k] : 13'($urandom_range(0, 4351));
      col_addr = c;
      #1;
      chk({col_ok, col_spare}, {c < 13'h1080 || (!on && c <= COL_LAST), c >= COL_SPARE});
      if (c < COL_PARITY) chk(col_sector, c >= COL_SPARE ? c[6:4] : c[11:9]);
      @(negedge clk);
    end
  endtask : cols

  // random per-sector counts; expectations follow the count encoding and threshold table
  task automatic page_read(input logic [3:0] thr, input logic on);
    logic [3:0] f, mx;
    logic [2:0] mi, rs;
    logic [7:0] fl;
    logic [1:0] oc;
    int v, k;
    mx = 4'h0; mi = 3'h0; fl = 8'h00;
    for (k = 0; k < 8; k++) begin
      v = $urandom_range(0, 9);
      f = (v == 9) ? CNT_UNCORR : 4'(v);
      flips[k*4 +: 4] = f;
      if (f > mx) begin mx = f; mi = 3'(k); end
      fl[k] = (thr == 4'hf) ? (f == CNT_UNCORR) : (f >= thr);
    end
    if (!on) begin mx = 4'h0; mi = 3'h0; fl = 8'h00; end
    oc = (mx == 4'h0) ? OUT_NONE : (mx == CNT_UNCORR) ? OUT_UNCORR : OUT_CORR;
    fset(FA_THRESH, {4'h0, thr});
    fset(FA_CFG, {3'h0, on, 4'h0});
    arm = 1'b1;
    cmd(CMD_PAGE_READ, 1'b0, rs);
    chk(rs, 3'b100);
    for (k = 0; k < 40 && dec_done !== 1'b1; k++) @(negedge clk);
    if (dec_done !== 1'b1) begin n_errors++; conclude(); end
    @(negedge clk);
    arm = 1'b0;
    fget(FA_CNT_LO, d); chk(d, on ? flips[15:0] : 16'h0);
    fget(FA_CNT_HI, d); chk(d, on ? flips[31:16] : 16'h0);
    fget(FA_MAX, d); chk(d[7:0], {mx, 1'b0, mi});
    fget(FA_STAT, d); chk(d[5:2], {oc, 2'b00});
    fget(FA_FLAGS, d); chk(d[7:0], prev_flags);
    cmd(CMD_READ_BUF, 1'b0, rs);
    fget(FA_FLAGS, d); chk(d[7:0], fl);
    fget(FA_STAT, d); chk(d[5:4], oc);
    prev_flags = fl;
  endtask : page_read

  initial begin
    #200000;
    n_errors++;
    conclude();
  end

  initial begin
    void'($urandom(9));
    repeat (16) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    chk({ecc_enabled, spare_size}, {ECC_EN_RST, SPARE_ON});
    fget(FA_THRESH, d); chk(d[3:0], THRESH_RST);
    fget(FA_CFG, d); chk(d[7:0], 8'h10);
    fget(FA_FLAGS, d); chk(d, 16'h0000);
    cols(1'b1);
    // bad blocks stay refused whichever way the enable bit is set
    for (i = 0; i < 4; i++) begin
      fset(FA_CFG, i[1] ? 8'h00 : 8'h10);
      cmd(i[0] ? CMD_ERASE : CMD_PROGRAM, 1'b1, r); chk(r, 3'b010);
      fget(FA_STAT, d); chk(d[3:2], i[0] ? 2'b01 : 2'b10);
    end
    fset(FA_CFG, 8'h10);
    cmd(CMD_PROGRAM, 1'b0, r); chk(r, 3'b101);
    fget(FA_STAT, d); chk(d[3:2], 2'b00);
    page_read(4'hf, 1'b1);
    page_read(4'h8, 1'b1);
    for (i = 0; i < 8; i++) page_read((i[2:0] == 3'h7) ? 4'hf : 4'(i + 1), 1'b1);
    fset(FA_CFG, 8'h00);
    chk({ecc_enabled, spare_size}, {1'b0, SPARE_OFF});
    cols(1'b0);
    fset(FA_CFG, 8'h00);
    cmd(CMD_PROGRAM, 1'b0, r); chk(r, 3'b100);
    page_read(4'h1, 1'b0);
    page_read(4'(1 + $urandom_range(0, 7)), 1'b1);
    conclude();
  end
endmodule : tb_nbe_ecc_guard
`default_nettype wire
